// file: dcp_pkg.sv
package dcp_pkg;

   localparam int          DCP_DW         = 32;
   localparam int          DCP_AW         = 8;
   localparam int          DCP_POLY_LENGTH_W     = 5;

   // Register byte offsets
   localparam logic [7:0]  DCP_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  DCP_OFS_DATA   = 8'h04;
   localparam logic [7:0]  DCP_OFS_XOR    = 8'h08;

   // Control register fields
   localparam int          DCP_TYPE_BIT   = 15;
   localparam int          DCP_POLY_LENGTH_LSB   = 0;
   localparam logic [31:0] DCP_CTRL_MASK  = 32'h0000801F;

   // Reset values
   localparam logic [31:0] DCP_CTRL_RST   = 32'h00000000;
   localparam logic [31:0] DCP_DATA_RST   = 32'h00000000;
   localparam logic [31:0] DCP_XOR_RST    = 32'h00000000;

   typedef enum logic {
      DCP_MODE_LFSR,
      DCP_MODE_IPHDR
   } dcp_mode_e;

   // Ones for every bit at or below the polynomial length
   function automatic logic [31:0] dcp_len_mask(input logic [4:0] poly_length);
      dcp_len_mask = 32'hFFFFFFFF >> (5'h1F - poly_length);
   endfunction

   // Sixteen-bit ones-complement addition with end-around carry
   function automatic logic [15:0] dcp_ones_add(input logic [15:0] a,
                                                input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      dcp_ones_add = s[15:0] + {15'h0000, s[16]};
   endfunction

endpackage

// file: dcp_lfsr_step.sv
`timescale 1ns/100ps
module dcp_lfsr_step
   import dcp_pkg::*;
(
   // Present state and configuration
   input  wire logic [31:0] i_state,
   input  wire logic [31:0] i_taps,
   input  wire logic [4:0]  i_poly_length,
   // Word to absorb
   input  wire logic [31:0] i_data,
   // Result after all 32 bits
   output logic      [31:0] o_next
);

   logic [31:0] s;
   logic        fb;

   // Word is shifted in MSB first; stage 0 always takes the feedback
   always_comb begin
      s  = i_state;
      fb = 1'b0;
      for (int k = 31; k >= 0; k--) begin
         fb   = s[i_poly_length] ^ i_data[k];
         s    = {s[30:0], 1'b0} ^ (i_taps & {32{fb}});
         s[0] = fb;
      end
      o_next = s & dcp_len_mask(i_poly_length);
   end

endmodule

// file: dcp_crc_data_path.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
module dcp_crc_data_path
   import dcp_pkg::*;
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // DMA data stream
   input  wire logic        i_dma_valid,
   input  wire logic [31:0] i_dma_data,
   // Present result
   output logic      [31:0] o_crc_value
);

   logic [1:0]  rst_sync;
   logic        rst_n;
   logic [31:0] ctrl;
   logic [31:0] crc_state;
   logic [31:0] taps;
   logic [31:0] next_state;
   logic [31:0] next_prdata;

   // Reset enters asynchronously, is released through two flops
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Decode
   wire         acc_phase = i_psel & i_penable;
   wire         commit    = acc_phase & o_pready;
   wire         hit_ctrl  = (i_paddr == DCP_OFS_CTRL);
   wire         hit_data  = (i_paddr == DCP_OFS_DATA);
   wire         hit_xor   = (i_paddr == DCP_OFS_XOR);
   wire         mapped    = hit_ctrl | hit_data | hit_xor;
   wire         wr_ctrl   = commit & i_pwrite & hit_ctrl;
   wire         wr_data   = commit & i_pwrite & hit_data;
   wire         wr_xor    = commit & i_pwrite & hit_xor;
   wire [4:0]   poly_length      = ctrl[DCP_POLY_LENGTH_LSB +: DCP_POLY_LENGTH_W];
   wire         ip_mode   = ctrl[DCP_TYPE_BIT];
   wire         len_mode  = (ip_mode == DCP_MODE_IPHDR);
   wire [31:0]  len_mask  = dcp_len_mask(poly_length);

   // Software view of the running value
   wire [31:0]  ip_view   = {16'h0000, ~crc_state[15:0]};
   wire [31:0]  lfsr_view = crc_state & len_mask;
   wire [31:0]  data_view = len_mode ? ip_view : lfsr_view;

   // Seed value; checksum mode keeps the raw sum so reads complement it
   wire [31:0]  seed      = len_mode ? {16'h0000, i_pwdata[15:0]}
                                     : i_pwdata;

   // Checksum step: both halves of the word folded in
   wire [15:0]  ip_half   = dcp_ones_add(crc_state[15:0],
                                         i_dma_data[31:16]);
   wire [31:0]  ip_next   = {16'h0000,
                             dcp_ones_add(ip_half, i_dma_data[15:0])};
   wire [31:0]  lfsr_next;

   dcp_lfsr_step u_step (
      .i_state (crc_state),
      .i_taps  (taps),
      .i_poly_length  (poly_length),
      .i_data  (i_dma_data),
      .o_next  (lfsr_next)
   );

   // A software seed outranks a DMA word in the same cycle
   always_comb begin
      next_state = crc_state;
      if (wr_data) begin
         next_state = seed;
      end else if (i_dma_valid) begin
         next_state = len_mode ? ip_next : lfsr_next;
      end
   end

   always_comb begin
      next_prdata = 32'h00000000;
      if (hit_ctrl) begin
         next_prdata = ctrl & DCP_CTRL_MASK;
      end else if (hit_data) begin
         next_prdata = data_view;
      end else if (hit_xor) begin
         next_prdata = taps;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl      <= DCP_CTRL_RST;
         taps      <= DCP_XOR_RST;
         crc_state <= DCP_DATA_RST;
      end else begin
         crc_state <= next_state;
         if (wr_ctrl) begin
            ctrl <= i_pwdata & DCP_CTRL_MASK;
         end
         if (wr_xor) begin
            taps <= i_pwdata;
         end
      end
   end

   // Fixed one wait state keeps every APB output on a flop
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_pready    <= 1'b0;
         o_pslverr   <= 1'b0;
         o_prdata    <= 32'h00000000;
         o_crc_value <= 32'h00000000;
      end else begin
         o_pready    <= acc_phase & ~o_pready;
         o_pslverr   <= acc_phase & ~o_pready & ~mapped;
         o_prdata    <= (acc_phase & ~o_pready & ~i_pwrite) ?
                        next_prdata : 32'h00000000;
         o_crc_value <= data_view;
      end
   end

   // Checks
   sequence seq_data_write;
      wr_data;
   endsequence

   sequence seq_dma_step;
      i_dma_valid && !wr_data;
   endsequence

   a_seed_load: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      seq_data_write |=> crc_state == $past(seed))
      else $error("seed write not loaded");

   a_read_value: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (acc_phase && !o_pready && !i_pwrite && hit_data)
      |=> o_pready && o_prdata == $past(data_view))
      else $error("data read returned wrong value");

   // Watches the answer on the bus, not the view that builds it
   a_high_zero: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (o_pready && !ip_mode && $past(hit_data && !i_pwrite))
      |-> (o_prdata & ~len_mask) == 32'h00000000)
      else $error("bits above length not zero");

   a_mode_pick: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (wr_ctrl && i_pwdata[DCP_TYPE_BIT]) ##1 !wr_ctrl[*2]
      |-> ip_mode)
      else $error("type bit did not select checksum mode");

   a_ip_upper: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      ip_mode |-> o_prdata[31:16] == 16'h0000 || !$past(hit_data))
      else $error("checksum upper half not zero");

   a_ip_complement: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (seq_data_write and ip_mode) |=>
      data_view == {16'h0000, ~$past(i_pwdata[15:0])})
      else $error("checksum readback not complemented");

   a_tap_pass: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (seq_dma_step and (!ip_mode && taps == 32'h00000000 &&
                         poly_length == 5'h1F))
      |=> crc_state == ($past(crc_state) ^ $past(i_dma_data)))
      else $error("clear taps did not pass bits through");

   a_ip_no_taps: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (seq_dma_step and ip_mode) |=> crc_state == $past(ip_next))
      else $error("checksum step disturbed by taps");

   a_idle_hold: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      (!i_dma_valid && !wr_data) |=> $stable(crc_state))
      else $error("state changed with no word or seed");

   a_pready_pulse: assert property (
      @(posedge i_mclk) disable iff (!rst_n)
      o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

endmodule

// file: tb_dma_crc_data_path.sv
`timescale 1ns/100ps
module tb_dma_crc_data_path;
   import dcp_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic        i_psel = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite = 1'b0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic        i_dma_valid = 1'b0;
   logic [31:0] i_dma_data = 32'h0;
   logic [31:0] o_prdata, o_crc_value, rd, exp;
   logic        o_pready, o_pslverr, er;
   logic [4:0]  p;
   int          miscompares = 0;
   int          checked = 0;
   // Control word, seed written, data readback expected
   logic [31:0] rows [5][3] = '{
      '{32'h0000001F, 32'hA5A5F00F, 32'hA5A5F00F},
      '{32'h00000007, 32'hDEADBEEF, 32'h000000EF},
      '{32'h00000000, 32'hFFFFFFFF, 32'h00000001},
      '{32'h00008000, 32'h12345678, 32'h0000A987},
      '{32'h0000801F, 32'hFFFF0000, 32'h0000FFFF}};

   dcp_crc_data_path dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_dma_valid(i_dma_valid), .i_dma_data(i_dma_data),
      .o_crc_value(o_crc_value));

   initial forever #50 i_mclk = ~i_mclk;

   task automatic final_report();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, want, seen);
      end
   endtask

   // Entered just after a rising edge; pready and read data are taken at
   // the rising edge. One idle edge follows so the next call never drives
   // psel twice in one step.
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk) i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
      if (n >= 20) begin
         miscompares++;
         final_report();
      end
   endtask

   // Reference shift, MSB first, tap 0 never used
   function automatic logic [31:0] lfsr(logic [31:0] s, logic [31:0] t,
                                        logic [31:0] d, logic [4:0] l);
      logic fb;
      for (int i = 31; i >= 0; i--) begin
         fb = s[l] ^ d[i];
         s = ((s << 1) ^ (t & 32'hFFFFFFFE & {32{fb}})) | {31'h0, fb};
      end
      return s & (32'hFFFFFFFF >> (5'd31 - l));
   endfunction

   function automatic logic [15:0] oadd(logic [15:0] a, logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0, s[16]};
   endfunction

   initial begin
      repeat (20) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      for (int a = 0; a < 12; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         chk("reset value", rd, 32'h0);
         chk("no error", {31'h0, er}, 32'h0);
      end
      chk("crc out", o_crc_value, 32'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, DCP_OFS_CTRL, rows[i][0]);
         apb(1'b1, DCP_OFS_DATA, rows[i][1]);
         apb(1'b0, DCP_OFS_DATA, 32'h0);
         chk("data", rd, rows[i][2]);
         apb(1'b0, DCP_OFS_CTRL, 32'h0);
         chk("ctrl", rd, rows[i][0]);
      end
      apb(1'b1, DCP_OFS_XOR, 32'h04C11DB7);
      apb(1'b0, DCP_OFS_XOR, 32'h0);
      chk("xor", rd, 32'h04C11DB7);
      for (int k = 0; k < 2; k++) begin
         p = k[0] ? 5'd12 : 5'd31;
         apb(1'b1, DCP_OFS_CTRL, {27'h0, p});
         apb(1'b1, DCP_OFS_DATA, 32'hFFFFFFFF);
         i_dma_valid <= 1'b1;
         i_dma_data <= 32'h31323334;
         @(posedge i_mclk) i_dma_data <= 32'hCAFE0001;
         @(posedge i_mclk) i_dma_valid <= 1'b0;
         exp = lfsr(32'hFFFFFFFF, 32'h04C11DB7, 32'h31323334, p);
         exp = lfsr(exp, 32'h04C11DB7, 32'hCAFE0001, p);
         apb(1'b0, DCP_OFS_DATA, 32'h0);
         chk("lfsr", rd, exp);
         chk("crc out", o_crc_value, exp);
      end
      // Taps stay set: checksum must ignore them
      apb(1'b1, DCP_OFS_CTRL, 32'h00008000);
      apb(1'b1, DCP_OFS_DATA, 32'h0000F0F0);
      i_dma_valid <= 1'b1;
      i_dma_data <= 32'h12348765;
      @(posedge i_mclk) i_dma_valid <= 1'b0;
      exp = {16'h0, ~oadd(oadd(16'hF0F0, 16'h1234), 16'h8765)};
      apb(1'b0, DCP_OFS_DATA, 32'h0);
      chk("checksum", rd, exp);
      apb(1'b1, 8'h0C, 32'h5A5A5A5A);
      chk("slverr", {31'h0, er}, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      apb(1'b0, DCP_OFS_DATA, 32'h0);
      chk("kept", rd, exp);
      // Reset in mid-run: taps and state are non-zero here
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("reset out", o_crc_value, 32'h0);
      apb(1'b0, DCP_OFS_DATA, 32'h0);
      chk("reset data", rd, 32'h0);
      apb(1'b0, DCP_OFS_XOR, 32'h0);
      chk("reset xor", rd, 32'h0);
      // Clear taps at full length: the word passes straight through
      apb(1'b1, DCP_OFS_CTRL, 32'h0000001F);
      apb(1'b1, DCP_OFS_DATA, 32'h0F0F0F0F);
      i_dma_valid <= 1'b1;
      i_dma_data <= 32'h12345678;
      @(posedge i_mclk) i_dma_valid <= 1'b0;
      apb(1'b0, DCP_OFS_DATA, 32'h0);
      chk("pass through", rd, 32'h1D3B5977);
      final_report();
   end
endmodule
